/* hdl/hcb_config_bank.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hcb_consts.svh"
module hcb_config_bank #(
	parameter int unsigned P_CYCLES_PER_MS = `HCB_MS_NS / `HCB_CLK_PERIOD_NS
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	input  wire logic        i_wr_en,
	input  wire logic        i_rd_en,
	input  wire logic [7:0]  i_addr,
	input  wire logic [7:0]  i_wr_data,
	output logic      [7:0]  o_rd_data,
	output logic             o_rd_valid,
	input  wire logic        i_self_powered_cfg,
	input  wire logic        i_dynamic_power_en,
	input  wire logic        i_local_power_sense,
	input  wire logic        i_internal_default,
	input  wire logic [1:0]  i_port_disable_straps,
	input  wire logic [3:0]  i_self_disable_mask,
	input  wire logic [3:0]  i_ownership_select_pins,
	input  wire logic [1:0]  i_char_sel,
	input  wire logic [4:0]  i_char_idx,
	output logic      [15:0] o_char_data,
	output logic             o_self_powered,
	output logic      [3:0]  o_port_disabled,
	output logic      [8:0]  o_max_power_ma,
	output logic      [8:0]  o_controller_current_ma,
	output logic      [8:0]  o_power_on_time_ms,
	output logic      [15:0] o_language_id,
	output logic      [7:0]  o_maker_text_length,
	output logic      [7:0]  o_product_text_length,
	output logic      [7:0]  o_serial_text_length,
	output hcb_pkg::hcb_owner_t o_port1_owner,
	output hcb_pkg::hcb_owner_t o_port2_owner,
	output logic      [3:0]  o_assign_stable_pins,
	output logic             o_assign_switch_pulse
);
	typedef struct packed {
		logic [3:0]          bp_mask;
		logic [7:0]          max_sp;
		logic [7:0]          max_bp;
		logic [7:0]          cur_sp;
		logic [7:0]          cur_bp;
		logic [7:0]          pon;
		logic [7:0]          lang_hi;
		logic [7:0]          lang_lo;
		logic [7:0]          maker_len;
		logic [7:0]          prod_len;
		logic [7:0]          ser_len;
		logic [7:0]          delay;
		logic [7:0]          table0;
		logic                sense_s1;
		logic                sense_s2;
		logic [1:0]          strap_s1;
		logic [1:0]          strap_s2;
		logic [7:0]          rd_data;
		logic                rd_text;
		logic                rd_valid;
		logic                local_power_sense;
		logic [3:0]          port_dis;
		logic [8:0]          max_ma;
		logic [8:0]          cur_ma;
		logic [8:0]          pon_ms;
		logic [15:0]         lang;
		hcb_pkg::hcb_owner_t own1;
		hcb_pkg::hcb_owner_t own2;
	} hcb_bank_t;

	typedef enum logic [3:0] {
		HCB_SEL_NONE      = 4'h0,
		HCB_SEL_BP_MASK   = 4'h1,
		HCB_SEL_MAX_SP    = 4'h2,
		HCB_SEL_MAX_BP    = 4'h3,
		HCB_SEL_CUR_SP    = 4'h4,
		HCB_SEL_CUR_BP    = 4'h5,
		HCB_SEL_PON       = 4'h6,
		HCB_SEL_LANG_HI   = 4'h7,
		HCB_SEL_LANG_LO   = 4'h8,
		HCB_SEL_MAKER_LEN = 4'h9,
		HCB_SEL_PROD_LEN  = 4'hA,
		HCB_SEL_SER_LEN   = 4'hB,
		HCB_SEL_DELAY     = 4'hC,
		HCB_SEL_TABLE0    = 4'hD
	} hcb_reg_sel_t;

	hcb_bank_t q;
	hcb_bank_t d;
	hcb_text_if txt ();
	hcb_reg_sel_t        sel;
	hcb_pkg::hcb_owner_t own_dec [`HCB_OWN_PORTS];

	// Address falls inside the three back-to-back text regions.
	function automatic logic is_text(input logic [7:0] a);
		return a >= `HCB_ADDR_TEXT_FIRST && a <= `HCB_ADDR_TEXT_LAST;
	endfunction

	// Straps count disabled ports downward from port four.
	function automatic logic [3:0] strap_mask(input logic [1:0] s);
		case (s)
		2'h0: strap_mask = 4'h0;
		2'h1: strap_mask = 4'h8;
		2'h2: strap_mask = 4'hC;
		2'h3: strap_mask = 4'hE;
		default: strap_mask = 4'h0;
		endcase
	endfunction

	function automatic hcb_pkg::hcb_owner_t owner(input logic [3:0] n);
		if (n == `HCB_OWN_CODE_NONE) begin
			owner = hcb_pkg::HCB_OWN_UNASSIGNED; // [R17]
		end else if (n == `HCB_OWN_CODE_HOST2) begin
			owner = hcb_pkg::HCB_OWN_HOST_TWO; // [R17]
		end else begin
			owner = hcb_pkg::HCB_OWN_HOST_ONE; // [R17] [R18]
		end
	endfunction

	// Writes and reads decode the offset in one place, so they cannot drift.
	function automatic hcb_reg_sel_t reg_sel(input logic [7:0] a);
		case (a)
		`HCB_ADDR_BP_DISABLE: begin
			reg_sel = HCB_SEL_BP_MASK;
		end
		`HCB_ADDR_MAX_PWR_SP: begin
			reg_sel = HCB_SEL_MAX_SP;
		end
		`HCB_ADDR_MAX_PWR_BP: begin
			reg_sel = HCB_SEL_MAX_BP;
		end
		`HCB_ADDR_CUR_SP: begin
			reg_sel = HCB_SEL_CUR_SP;
		end
		`HCB_ADDR_CUR_BP: begin
			reg_sel = HCB_SEL_CUR_BP;
		end
		`HCB_ADDR_PON_TIME: begin
			reg_sel = HCB_SEL_PON;
		end
		`HCB_ADDR_LANG_HI: begin
			reg_sel = HCB_SEL_LANG_HI;
		end
		`HCB_ADDR_LANG_LO: begin
			reg_sel = HCB_SEL_LANG_LO;
		end
		`HCB_ADDR_MAKER_LEN: begin
			reg_sel = HCB_SEL_MAKER_LEN;
		end
		`HCB_ADDR_PROD_LEN: begin
			reg_sel = HCB_SEL_PROD_LEN;
		end
		`HCB_ADDR_SER_LEN: begin
			reg_sel = HCB_SEL_SER_LEN;
		end
		`HCB_ADDR_DELAY: begin
			reg_sel = HCB_SEL_DELAY;
		end
		`HCB_ADDR_OWN_TABLE0: begin
			reg_sel = HCB_SEL_TABLE0;
		end
		default: begin
			reg_sel = HCB_SEL_NONE;
		end
		endcase
	endfunction

	// Every power, current and time byte counts in steps of two units.
	function automatic logic [8:0] in_units_2(input logic [7:0] b);
		return 9'(b) * `HCB_UNIT_2;
	endfunction

	// Text bytes are written straight through to the store.
	assign txt.wr_en    = i_wr_en && is_text(i_addr);
	assign txt.wr_idx   = i_addr - `HCB_ADDR_TEXT_FIRST;
	assign txt.wr_data  = i_wr_data;
	assign txt.rd_idx   = i_addr - `HCB_ADDR_TEXT_FIRST;
	assign txt.char_sel = i_char_sel;
	assign txt.char_idx = i_char_idx;
	assign sel          = reg_sel(i_addr);

	// Each table nibble names the owner of one downstream port.
	for (genvar p = 0; p < `HCB_OWN_PORTS; p++) begin : g_owner // [R17]
		assign own_dec[p] =
			owner(q.table0[p*`HCB_NIB_W +: `HCB_NIB_W]);
	end

	hcb_text_store u_text (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.txt       (txt.store)
	);

	hcb_assign_debounce #(
		.P_CYCLES_PER_MS (P_CYCLES_PER_MS)
	) u_debounce (
		.i_ref_clk               (i_ref_clk),
		.i_rst                   (i_rst),
		.i_ownership_select_pins (i_ownership_select_pins),
		.i_delay_ms              (q.delay),
		.o_stable_pins           (o_assign_stable_pins),
		.o_switch_pulse          (o_assign_switch_pulse)
	);

	always_comb begin
		d = q;
		d.sense_s1 = i_local_power_sense;
		d.sense_s2 = q.sense_s1;
		d.strap_s1 = i_port_disable_straps;
		d.strap_s2 = q.strap_s1;

		if (i_wr_en) begin
			case (sel)
			HCB_SEL_BP_MASK: begin
				// Bit 0 and bits 7:5 are not stored, so they read zero.
				d.bp_mask = i_wr_data[`HCB_MASK_MSB:`HCB_MASK_LSB]; // [R2]
			end
			HCB_SEL_MAX_SP: begin
				d.max_sp = i_wr_data;
			end
			HCB_SEL_MAX_BP: begin
				d.max_bp = i_wr_data;
			end
			HCB_SEL_CUR_SP: begin
				d.cur_sp = i_wr_data;
			end
			HCB_SEL_CUR_BP: begin
				d.cur_bp = i_wr_data;
			end
			HCB_SEL_PON: begin
				d.pon = i_wr_data;
			end
			HCB_SEL_LANG_HI: begin
				d.lang_hi = i_wr_data;
			end
			HCB_SEL_LANG_LO: begin
				d.lang_lo = i_wr_data;
			end
			HCB_SEL_MAKER_LEN: begin
				d.maker_len = i_wr_data;
			end
			HCB_SEL_PROD_LEN: begin
				d.prod_len = i_wr_data;
			end
			HCB_SEL_SER_LEN: begin
				d.ser_len = i_wr_data;
			end
			HCB_SEL_DELAY: begin
				d.delay = i_wr_data;
			end
			HCB_SEL_TABLE0: begin
				d.table0 = i_wr_data;
			end
			default: begin
				d.table0 = q.table0;
			end
			endcase
		end

		d.rd_valid = i_rd_en;
		d.rd_text = i_rd_en && is_text(i_addr);
		if (i_rd_en) begin
			case (sel)
			HCB_SEL_BP_MASK: begin
				d.rd_data = {3'h0, q.bp_mask, 1'h0}; // [R2]
			end
			HCB_SEL_MAX_SP: begin
				d.rd_data = q.max_sp;
			end
			HCB_SEL_MAX_BP: begin
				d.rd_data = q.max_bp;
			end
			HCB_SEL_CUR_SP: begin
				d.rd_data = q.cur_sp;
			end
			HCB_SEL_CUR_BP: begin
				d.rd_data = q.cur_bp;
			end
			HCB_SEL_PON: begin
				d.rd_data = q.pon;
			end
			HCB_SEL_LANG_HI: begin
				d.rd_data = q.lang_hi;
			end
			HCB_SEL_LANG_LO: begin
				d.rd_data = q.lang_lo;
			end
			HCB_SEL_MAKER_LEN: begin
				d.rd_data = q.maker_len;
			end
			HCB_SEL_PROD_LEN: begin
				d.rd_data = q.prod_len;
			end
			HCB_SEL_SER_LEN: begin
				d.rd_data = q.ser_len;
			end
			HCB_SEL_DELAY: begin
				d.rd_data = q.delay;
			end
			HCB_SEL_TABLE0: begin
				d.rd_data = q.table0;
			end
			default: begin
				d.rd_data = `HCB_RESET_BYTE;
			end
			endcase
		end

		// With dynamic switching the sensed supply overrides the mode bit.
		d.local_power_sense = i_dynamic_power_en ? q.sense_s2 : i_self_powered_cfg; // [R20]
		if (i_internal_default) begin
			d.port_dis = strap_mask(q.strap_s2); // [R4]
		end else if (q.local_power_sense) begin
			d.port_dis = i_self_disable_mask;
		end else begin
			d.port_dis = q.bp_mask; // [R1]
		end
		if (q.local_power_sense) begin
			d.max_ma = in_units_2(q.max_sp); // [R5]
			d.cur_ma = in_units_2(q.cur_sp); // [R9]
		end else begin
			d.max_ma = in_units_2(q.max_bp); // [R6]
			d.cur_ma = in_units_2(q.cur_bp); // [R10]
		end
		d.pon_ms = in_units_2(q.pon); // [R11]
		d.lang = {q.lang_hi, q.lang_lo}; // [R12]
		d.own1 = own_dec[0];
		d.own2 = own_dec[1];
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			q <= '0; // [R19]
		end else begin
			q <= d;
		end
	end

	// Text bytes come from the store's own flop, so both paths take one cycle.
	assign o_rd_data               = q.rd_text ? txt.rd_byte : q.rd_data;
	assign o_rd_valid              = q.rd_valid;
	assign o_char_data             = txt.char_data;
	assign o_self_powered          = q.local_power_sense;
	assign o_port_disabled         = q.port_dis;
	assign o_max_power_ma          = q.max_ma;
	assign o_controller_current_ma = q.cur_ma;
	assign o_power_on_time_ms      = q.pon_ms;
	assign o_language_id           = q.lang;
	assign o_maker_text_length     = q.maker_len;
	assign o_product_text_length   = q.prod_len;
	assign o_serial_text_length    = q.ser_len;
	assign o_port1_owner           = q.own1;
	assign o_port2_owner           = q.own2;
endmodule
`default_nettype wire

/* hdl/hcb_consts.svh */
`ifndef HCB_CONSTS_SVH
`define HCB_CONSTS_SVH
// How it works
// [R1] Bus-powered mask bits 4..1 disable those ports.
// [R2] Mask bit 0 is reserved, reads zero.
// [R3] Loader disables contiguous ports downward from port four.
// [R4] Internal default takes disabled ports from straps.
// [R5] Self-powered maximum power is byte times 2 mA.
// [R6] Bus-powered maximum power is byte times 2 mA.
// [R7] Loader folds embedded peripheral into maximum power.
// [R8] Loader keeps self-powered values within 100 mA.
// [R9] Self-powered controller current counts in 2 mA.
// [R10] Bus-powered controller current counts in 2 mA.
// [R11] Power-on time reported in 2 ms units.
// [R12] Language identifier joins upper and lower bytes.
// [R13] Loader keeps each text length at most 31.
// [R14] Characters stored low byte first, ascending addresses.
// [R15] Maker and product text take consecutive 62-byte regions.
// [R16] Wait programmed milliseconds before switching port owners.
// [R17] Table nibbles give owners of ports two, one.
// [R18] Ownership codes three to fifteen mean host one.
// [R19] Every register and text byte resets to zero.
// [R20] Dynamic power uses sense pin for power mode.
// [R21] Pin change during wait restarts the delay.
`define HCB_ADDR_BP_DISABLE  8'h0B
`define HCB_ADDR_MAX_PWR_SP  8'h0C
`define HCB_ADDR_MAX_PWR_BP  8'h0D
`define HCB_ADDR_CUR_SP      8'h0E
`define HCB_ADDR_CUR_BP      8'h0F
`define HCB_ADDR_PON_TIME    8'h10
`define HCB_ADDR_LANG_HI     8'h11
`define HCB_ADDR_LANG_LO     8'h12
`define HCB_ADDR_MAKER_LEN   8'h13
`define HCB_ADDR_PROD_LEN    8'h14
`define HCB_ADDR_SER_LEN     8'h15
`define HCB_ADDR_TEXT_FIRST  8'h16
`define HCB_ADDR_TEXT_LAST   8'hCF
`define HCB_ADDR_DELAY       8'hD0
`define HCB_ADDR_OWN_TABLE0  8'hD1
`define HCB_TEXT_DEPTH       186
`define HCB_TEXT_REGION      8'h3E
`define HCB_TEXT_LAST_CHAR   5'h1E
`define HCB_RESET_BYTE       8'h00
`define HCB_MASK_LSB         1
`define HCB_MASK_MSB         4
`define HCB_OWN_CODE_NONE    4'h0
`define HCB_OWN_CODE_HOST2   4'h2
`define HCB_OWN_PORTS        2
`define HCB_NIB_W            4
`define HCB_UNIT_2           9'h002
`define HCB_MS_NS            1000000
`define HCB_CLK_PERIOD_NS    10
`endif

/* hdl/hcb_pkg.sv */
package hcb_pkg;
	typedef enum logic [1:0] {
		HCB_OWN_UNASSIGNED = 2'h0,
		HCB_OWN_HOST_ONE   = 2'h1,
		HCB_OWN_HOST_TWO   = 2'h2
	} hcb_owner_t;
	typedef enum logic {
		HCB_DB_IDLE = 1'h0,
		HCB_DB_WAIT = 1'h1
	} hcb_db_state_t;
endpackage

/* hdl/hcb_text_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface hcb_text_if;
	logic        wr_en;
	logic [7:0]  wr_idx;
	logic [7:0]  wr_data;
	logic [7:0]  rd_idx;
	logic [7:0]  rd_byte;
	logic [1:0]  char_sel;
	logic [4:0]  char_idx;
	logic [15:0] char_data;
	modport bank (output wr_en, wr_idx, wr_data, rd_idx, char_sel, char_idx,
		input rd_byte, char_data);
	modport store (input wr_en, wr_idx, wr_data, rd_idx, char_sel, char_idx,
		output rd_byte, char_data);
endinterface
`default_nettype wire

/* hdl/hcb_text_store.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hcb_consts.svh"
module hcb_text_store (
	input wire logic   i_ref_clk,
	input wire logic   i_rst,
	hcb_text_if.store  txt
);
	typedef struct packed {
		logic [`HCB_TEXT_DEPTH-1:0][7:0] mem;
		logic [7:0]                      rd_byte;
		logic [15:0]                     char_data;
	} hcb_store_state_t;

	hcb_store_state_t q;
	hcb_store_state_t d;
	logic [7:0]       base;

	always_comb begin
		d = q;
		base = 8'(txt.char_sel * `HCB_TEXT_REGION) + {2'h0, txt.char_idx, 1'h0};
		if (txt.wr_en && txt.wr_idx < 8'(`HCB_TEXT_DEPTH)) begin
			d.mem[txt.wr_idx] = txt.wr_data;
		end
		d.rd_byte = `HCB_RESET_BYTE;
		if (txt.rd_idx < 8'(`HCB_TEXT_DEPTH)) begin
			d.rd_byte = q.mem[txt.rd_idx];
		end
		d.char_data = 16'h0000;
		// Serial region sits right after product text; index 31 is outside.
		if (txt.char_sel != 2'h3 && txt.char_idx <= `HCB_TEXT_LAST_CHAR) begin
			d.char_data = {q.mem[base + 8'h01], q.mem[base]}; // [R14] [R15]
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			q <= '0; // [R19]
		end else begin
			q <= d;
		end
	end

	assign txt.rd_byte   = q.rd_byte;
	assign txt.char_data = q.char_data;
endmodule
`default_nettype wire

/* hdl/hcb_assign_debounce.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hcb_consts.svh"
module hcb_assign_debounce #(
	parameter int unsigned P_CYCLES_PER_MS = `HCB_MS_NS / `HCB_CLK_PERIOD_NS
) (
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst,
	input  wire logic [3:0] i_ownership_select_pins,
	input  wire logic [7:0] i_delay_ms,
	output logic      [3:0] o_stable_pins,
	output logic            o_switch_pulse
);
	localparam int unsigned W = $clog2(P_CYCLES_PER_MS + 1);

	typedef struct packed {
		logic [3:0]            sync1;
		logic [3:0]            sync2;
		logic [3:0]            seen;
		logic [3:0]            stable;
		logic                  pulse;
		hcb_pkg::hcb_db_state_t st;
		logic [W-1:0]          prescale;
		logic [7:0]            ms_cnt;
	} hcb_db_t;

	hcb_db_t q;
	hcb_db_t d;

	always_comb begin
		d = q;
		d.sync1 = i_ownership_select_pins;
		d.sync2 = q.sync1;
		d.pulse = 1'h0;
		case (q.st)
		hcb_pkg::HCB_DB_IDLE: begin
			if (q.sync2 != q.stable) begin
				d.seen = q.sync2;
				d.prescale = '0;
				d.ms_cnt = 8'h00;
				d.st = hcb_pkg::HCB_DB_WAIT;
			end
		end
		hcb_pkg::HCB_DB_WAIT: begin
			if (q.sync2 != q.seen) begin
				d.seen = q.sync2; // [R21]
				d.prescale = '0;
				d.ms_cnt = 8'h00;
			end else if (q.ms_cnt >= i_delay_ms) begin
				d.stable = q.seen; // [R16]
				d.pulse = 1'h1;
				d.st = hcb_pkg::HCB_DB_IDLE;
			end else if (q.prescale == W'(P_CYCLES_PER_MS - 1)) begin
				d.prescale = '0;
				d.ms_cnt = q.ms_cnt + 8'h01;
			end else begin
				d.prescale = q.prescale + W'(1);
			end
		end
		default: begin
			d.st = hcb_pkg::HCB_DB_IDLE;
		end
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign o_stable_pins  = q.stable;
	assign o_switch_pulse = q.pulse;
endmodule
`default_nettype wire

/* tb/hcb_config_bank_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module hcb_config_bank_properties #(
	parameter int unsigned P_CYCLES_PER_MS = 100000
) (
	input wire logic        i_ref_clk,
	input wire logic        i_rst,
	input wire logic        i_wr_en,
	input wire logic        i_rd_en,
	input wire logic [7:0]  i_addr,
	input wire logic [7:0]  i_wr_data,
	input wire logic [7:0]  o_rd_data,
	input wire logic        o_rd_valid,
	input wire logic        i_internal_default,
	input wire logic [3:0]  i_ownership_select_pins,
	input wire logic        o_self_powered,
	input wire logic [3:0]  o_port_disabled,
	input wire logic [8:0]  o_max_power_ma,
	input wire logic [15:0] o_language_id,
	input wire logic [3:0]  o_assign_stable_pins,
	input wire logic        o_assign_switch_pulse
);
	logic [3:0]  pins_q;
	logic [7:0]  delay_q;
	logic [19:0] since_q;
	// Counts from the raw pin move, so the sync stages only add slack.
	always_ff @(posedge i_ref_clk) begin
		pins_q <= i_ownership_select_pins;
		if (i_rst)
			delay_q <= 8'h00;
		else if (i_wr_en && i_addr == 8'hD0)
			delay_q <= i_wr_data;
		if (i_rst || pins_q != i_ownership_select_pins)
			since_q <= 20'h00000;
		else if (since_q != 20'hFFFFF)
			since_q <= since_q + 20'h00001;
	end
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);
	sequence s_wr(logic [7:0] a);
		i_wr_en && i_addr == a ##1 !(i_wr_en && i_addr == a);
	endsequence
	a_mask_bit_zero: assert property (i_rd_en && i_addr == 8'h0B |=>
		o_rd_valid && o_rd_data[0] == 1'b0 && o_rd_data[7:5] == 3'h0)
		else $error("mask reserved bits not zero");
	a_mask_bus_ports: assert property (s_wr(8'h0B) |-> ##1
		(o_self_powered || i_internal_default ||
		o_port_disabled == $past(i_wr_data[4:1], 2)))
		else $error("bus disable mask not applied");
	a_max_self_units: assert property (s_wr(8'h0C) |-> ##1
		(!o_self_powered || $changed(o_self_powered) ||
		o_max_power_ma == {$past(i_wr_data, 2), 1'b0}))
		else $error("self max power not in 2 mA units");
	a_lang_upper_byte: assert property (s_wr(8'h11) |-> ##1
		o_language_id[15:8] == $past(i_wr_data, 2))
		else $error("language id upper byte wrong");
	a_reset_clears: assert property (disable iff (1'b0)
		i_rst [*3] |-> o_language_id == 16'h0000 &&
		o_max_power_ma == 9'h000 && !o_rd_valid)
		else $error("outputs not cleared by reset");
	a_pulse_single: assert property (o_assign_switch_pulse |=>
		!o_assign_switch_pulse)
		else $error("switch pulse longer than one cycle");
	a_stable_with_pulse: assert property ($changed(o_assign_stable_pins)
		|-> o_assign_switch_pulse)
		else $error("stable pins moved without pulse");
	a_wait_full_delay: assert property (o_assign_switch_pulse |->
		since_q >= delay_q * P_CYCLES_PER_MS)
		else $error("switch before full delay");
endmodule
bind hcb_config_bank hcb_config_bank_properties #(
	.P_CYCLES_PER_MS(P_CYCLES_PER_MS)
) u_props (.i_ref_clk, .i_rst, .i_wr_en, .i_rd_en, .i_addr, .i_wr_data,
	.o_rd_data, .o_rd_valid, .i_internal_default,
	.i_ownership_select_pins, .o_self_powered, .o_port_disabled,
	.o_max_power_ma, .o_language_id, .o_assign_stable_pins,
	.o_assign_switch_pulse);
`default_nettype wire

/* tb/hcb_loader_model.sv */
`timescale 1ns/1ps
`default_nettype none
module hcb_loader_model (
	input  wire logic       i_ref_clk,
	input  wire logic [7:0] i_rd_data,
	input  wire logic       i_rd_valid,
	output logic            o_wr_en,
	output logic            o_rd_en,
	output logic      [7:0] o_addr,
	output logic      [7:0] o_wr_data
);
	initial begin
		o_wr_en = 1'b0;
		o_rd_en = 1'b0;
		o_addr = 8'h00;
		o_wr_data = 8'h00;
	end
	// An idle bus shows the inverse of its last value, not a kind constant.
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_ref_clk);
		o_wr_en = 1'b1;
		o_addr = a;
		o_wr_data = d;
		@(negedge i_ref_clk);
		o_wr_en = 1'b0;
		o_addr = ~a;
		o_wr_data = ~d;
	endtask
	task automatic get(input logic [7:0] a, output logic [8:0] r);
		@(negedge i_ref_clk);
		o_rd_en = 1'b1;
		o_addr = a;
		@(negedge i_ref_clk);
		o_rd_en = 1'b0;
		o_addr = ~a;
		r = {i_rd_valid, i_rd_data};
	endtask
	task automatic put_mask(input int n, input logic [7:0] junk);
		put(8'h0B, 8'((8'h1E << (4 - n)) & 8'h1E) | (junk & 8'hE1));
	endtask
	task automatic put_char(input logic [7:0] b, input logic [4:0] i,
		input logic [15:0] ch);
		put(8'(b + {i, 1'b0}), ch[7:0]);
		put(8'(b + {i, 1'b0} + 1), ch[15:8]);
	endtask
endmodule
`default_nettype wire

/* tb/tb_hub_config_power_string_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_hub_config_power_string_bank;
	localparam int unsigned P_MS = 4;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        cfg = 1'b0;
	logic        dyn = 1'b0;
	logic        sns = 1'b0;
	logic        idf = 1'b0;
	logic [1:0]  stp = 2'h0;
	logic [3:0]  smk = 4'h0;
	logic [3:0]  pin = 4'h0;
	logic [1:0]  csl = 2'h0;
	logic [4:0]  cix = 5'h00;
	logic        we, re, rv, sp, sw;
	logic [7:0]  ad, wd, rd, l0, l1, l2;
	logic [15:0] cd, lid;
	logic [8:0]  mp, cc, pt;
	logic [3:0]  pd, stb;
	hcb_pkg::hcb_owner_t ow1, ow2;
	logic [2:0]  mt [4] = '{3'h0, 3'h1, 3'h6, 3'h5};
	logic [3:0]  sx [4] = '{4'h0, 4'h8, 4'hC, 4'hE};
	int          dl [3] = '{0, 255, 3};
	int          miscompares = 0;
	int          tests_run = 0;
	int          cyc = 0;
	always #5 clk = ~clk;
	hcb_config_bank #(.P_CYCLES_PER_MS(P_MS)) u_dut (
		.i_ref_clk(clk), .i_rst(rst), .i_wr_en(we), .i_rd_en(re),
		.i_addr(ad), .i_wr_data(wd), .o_rd_data(rd), .o_rd_valid(rv),
		.i_self_powered_cfg(cfg), .i_dynamic_power_en(dyn),
		.i_local_power_sense(sns), .i_internal_default(idf),
		.i_port_disable_straps(stp), .i_self_disable_mask(smk),
		.i_ownership_select_pins(pin), .i_char_sel(csl),
		.i_char_idx(cix), .o_char_data(cd), .o_self_powered(sp),
		.o_port_disabled(pd), .o_max_power_ma(mp),
		.o_controller_current_ma(cc), .o_power_on_time_ms(pt),
		.o_language_id(lid), .o_maker_text_length(l0),
		.o_product_text_length(l1), .o_serial_text_length(l2),
		.o_port1_owner(ow1), .o_port2_owner(ow2),
		.o_assign_stable_pins(stb), .o_assign_switch_pulse(sw));
	hcb_loader_model u_ldr (.i_ref_clk(clk), .i_rd_data(rd),
		.i_rd_valid(rv), .o_wr_en(we), .o_rd_en(re), .o_addr(ad),
		.o_wr_data(wd));
	function automatic hcb_pkg::hcb_owner_t own(input logic [3:0] c);
		if (c == 4'h0)
			return hcb_pkg::HCB_OWN_UNASSIGNED;
		if (c == 4'h2)
			return hcb_pkg::HCB_OWN_HOST_TWO;
		return hcb_pkg::HCB_OWN_HOST_ONE;
	endfunction
	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value at %0t: %h %h", $time, g, e);
		end
	endtask
	task automatic cmp_rng(input int g, input int lo, input int hi);
		tests_run++;
		if (g < lo || g > hi) begin
			miscompares++;
			$display("wrong value at %0t: %h %h", $time, g, lo);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [8:0] r;
		u_ldr.get(a, r);
		cmp(16'(r), {8'h01, e});
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wait_sw(output int n);
		n = 0;
		while (sw !== 1'b1 && n < 2000) begin
			@(negedge clk);
			n++;
		end
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// The ceiling is some ten times the expected run length.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			final_report();
		end
	end
	initial begin
		int n;
		logic s;
		logic [7:0] a, b, c, e;
		logic [15:0] ch;
		void'($urandom(96));
		tick(8);
		rst = 1'b0;
		cmp({lid[7:0], mp[7:0]}, 16'h0000);
		for (int i = 0; i < 256; i++)
			rd_chk(8'(i), 8'h00);
		$display("test reset done");
		for (int m = 0; m < 4; m++) begin
			{dyn, sns, cfg} = mt[m];
			tick(6);
			a = 8'($urandom_range(50));
			b = 8'($urandom);
			c = 8'($urandom_range(50));
			e = 8'($urandom);
			u_ldr.put(8'h0C, a);
			u_ldr.put(8'h0D, b);
			u_ldr.put(8'h0E, c);
			u_ldr.put(8'h0F, e);
			u_ldr.put(8'h10, b ^ e);
			tick(3);
			s = mt[m][2] ? mt[m][1] : mt[m][0];
			cmp(sp, s);
			cmp(mp, s ? {a, 1'b0} : {b, 1'b0});
			cmp(cc, s ? {c, 1'b0} : {e, 1'b0});
			cmp(pt, {b ^ e, 1'b0});
			rd_chk(8'h0C, a);
		end
		a = 8'($urandom);
		b = 8'($urandom);
		c = 8'($urandom_range(31));
		e = 8'($urandom_range(31));
		u_ldr.put(8'h11, a);
		u_ldr.put(8'h12, b);
		u_ldr.put(8'h13, 8'h1F);
		u_ldr.put(8'h14, e);
		u_ldr.put(8'h15, c);
		tick(3);
		cmp(lid, {a, b});
		cmp({l0, l1}, {8'h1F, e});
		cmp(l2, c);
		$display("test power done");
		for (int k = 0; k < 16; k++) begin
			u_ldr.put(8'hD1, {4'(15 - k), 4'(k)});
			tick(3);
			cmp(ow1, own(4'(k)));
			cmp(ow2, own(4'(15 - k)));
		end
		{dyn, sns, cfg} = 3'h0;
		for (int k = 0; k <= 4; k++) begin
			u_ldr.put_mask(k, 8'($urandom));
			e = 8'((8'h1E << (4 - k)) & 8'h1E);
			tick(3);
			rd_chk(8'h0B, e);
			cmp(pd, e[4:1]);
		end
		idf = 1'b1;
		for (int k = 0; k < 4; k++) begin
			stp = 2'(k);
			tick(6);
			cmp(pd, sx[k]);
		end
		{idf, cfg, smk} = {2'h1, 4'($urandom)};
		tick(6);
		cmp(pd, smk);
		$display("test owners done");
		for (int q = 0; q < 3; q++) begin
			a = 8'(8'h16 + 8'h3E * q);
			for (int i = 0; i < 31; i += 30) begin
				ch = 16'($urandom);
				u_ldr.put_char(a, 5'(i), ch);
				{csl, cix} = {2'(q), 5'(i)};
				tick(2);
				cmp(cd, ch);
			end
			rd_chk(8'(a + 8'h3D), ch[15:8]);
		end
		csl = 2'h3;
		tick(2);
		cmp(cd, 16'h0000);
		{csl, cix} = {2'h0, 5'h1F};
		tick(2);
		cmp(cd, 16'h0000);
		$display("test text done");
		for (int k = 0; k < 3; k++) begin
			u_ldr.put(8'hD0, 8'(dl[k]));
			pin = pin ^ 4'(1 + $urandom_range(14));
			wait_sw(n);
			cmp_rng(n, dl[k] * P_MS, dl[k] * P_MS + 8);
			cmp(stb, pin);
		end
		pin = pin ^ 4'h5;
		tick(6);
		pin = pin ^ 4'hA;
		wait_sw(n);
		cmp_rng(n, 3 * P_MS, 3 * P_MS + 8);
		cmp(stb, pin);
		$display("test debounce done");
		final_report();
	end
endmodule
`default_nettype wire
